//--- src/pic_defs.svh
// Purpose: constants of the prioritized interrupt controller
// Assumes: 32-bit classic Wishbone register bus
// Notes: byte offsets of the word registers
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_OFS_ICM      6'h00
`define PIC_OFS_RCR      6'h04
`define PIC_OFS_PRIO     6'h08
`define PIC_OFS_PERI     6'h0C
`define PIC_OFS_STAT     6'h10
`define PIC_B_GHI        7
`define PIC_B_GLO        6
`define PIC_B_T0E        5
`define PIC_B_X0E        4
`define PIC_B_PCE        3
`define PIC_B_T0F        2
`define PIC_B_X0F        1
`define PIC_B_PCF        0
`define PIC_B_PSE        7
`define PIC_VEC_HIGH     21'h000008
`define PIC_VEC_LOW      21'h000018
`define PIC_LAT_CYC      2'h3
`endif

//--- src/pic_pkg.sv
// Purpose: types of the prioritized interrupt controller
// Assumes: nothing
// Notes: state codes are one-hot
package pic_pkg;
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_WAIT = 3'b010,
    PIC_TAKE = 3'b100
  } pic_state_e;
  typedef logic [20:0] pic_addr_t;
endpackage : pic_pkg

//--- src/pic_sync.sv
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs are asynchronous to sys_clk_i
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module pic_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : pic_sync

//--- src/pic_wb.sv
// Purpose: classic Wishbone slave front end
// Assumes: one access at a time, ack after one wait state
// Notes: ack drops the cycle after it was given
`timescale 1ns/10ps
module pic_wb (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  // Access strobe to the register file
  output logic             acc_o
);
  assign acc_o = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= acc_o;
  end
endmodule : pic_wb

//--- src/pic_ctrl.sv
// Purpose: two-level prioritized interrupt controller with vector request to the core
// Assumes: core sends one-cycle retire/return pulses; sources give one-cycle event pulses
// Notes: registers over classic Wishbone, ack one cycle after request
// Summary of operation
// - High priority vectors to 0008h, low priority to 0018h.
// - High-priority request may preempt a running low-priority routine.
// - Two-level scheme active only while priority scheme enable is set.
// - With priorities, high enable unmasks all high-priority sources.
// - Low-priority sources need both low and high enables set.
// - Flag, enable and global enable set vector by priority after three wait cycles and an instruction end.
// - Priority scheme off by default; all vectors go to 0008h.
// - Compatibility: bit 6 gates peripherals, bit 7 gates everything.
// - Acceptance clears the governing global enable bit.
// - Low-priority processing held off during a high-priority routine.
// - Acceptance pushes return address and loads vector into program counter.
// - Return instruction leaves routine and sets the cleared enable again.
// - External events vector three to four instruction cycles later.
// - Flags set on every condition regardless of any enable.
// - Bit 7 global enable, or high enable with priorities on.
// - Bit 6 peripheral enable, or enable of all low-priority sources with priorities on.
// - Bit 2 latches timer-zero overflow; bit 5 enables it.
// - Bit 1 latches external pin zero; bit 4 enables it.
// - Bit 0 sets on port B upper nibble change; bit 3 enables.
// - Persisting port mismatch keeps setting change flag until port read.
`timescale 1ns/10ps
`include "pic_defs.svh"
module pic_ctrl (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rstn_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [5:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Event sources
  input  wire logic                 timer_zero_ovf_i,
  input  wire logic                 ext_pin_zero_i,
  input  wire logic [3:0]           port_b_input_i,
  input  wire logic                 port_b_read_i,
  input  wire logic [7:0]           periph_req_i,
  // Core interface
  input  wire logic                 instr_end_i,
  input  wire logic                 return_from_service_instr_i,
  input  wire pic_pkg::pic_addr_t   return_addr_i,
  output logic                      vector_req_o,
  output pic_pkg::pic_addr_t        vector_addr_o,
  output logic                      stack_push_o,
  output pic_pkg::pic_addr_t        stack_data_o,
  output logic                      in_high_o,
  output logic                      in_low_o
);
  logic       rst_m;
  logic       rst_n;
  logic [7:0] icm;
  logic [2:0] flg;
  logic [7:3] ena;
  logic       priority_scheme_enable;
  logic [2:0] prio;
  logic [7:0] peri_en;
  logic [7:0] peri_prio;
  logic       ext_s;
  logic       ext_q;
  logic [3:0] pb_s;
  logic [3:0] pb_latch;
  logic       acc;
  logic       wr;
  logic [2:0] fl_set;
  logic [2:0] fl_clr;
  logic [2:0] src_en;
  logic [2:0] src_fl;
  logic       req_hi;
  logic       req_lo;
  logic       pend_hi;
  logic       take_hi;
  logic [1:0] lat_cnt;
  pic_pkg::pic_state_e state;
  pic_pkg::pic_state_e next_state;

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  pic_wb u_wb (
    .sys_clk_i (sys_clk_i),
    .rst_n     (rst_n),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_ack_o  (wb_ack_o),
    .acc_o     (acc)
  );

  pic_sync #(.W(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rst_n),
    .d_i       ({ext_pin_zero_i, port_b_input_i}),
    .q_o       ({ext_s, pb_s})
  );

  // Write takes effect at the acknowledging edge
  assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

  // Event detection: rising edge on pin zero, mismatch against last port read
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_q    <= 1'b0;
      pb_latch <= 4'h0;
    end
    else
    begin
      ext_q <= ext_s;
      if (port_b_read_i)
        pb_latch <= pb_s;
    end
  end

  assign fl_set[0] = (pb_s != pb_latch);
  assign fl_set[1] = ext_s && !ext_q;
  assign fl_set[2] = timer_zero_ovf_i;
  assign fl_clr    = wr && (wb_adr_i == `PIC_OFS_ICM) ? ~wb_dat_i[2:0] : 3'h0;

  // Flags: set wins over clear, independent of any enable
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      flg <= 3'h0;
    else
      flg <= (flg & ~fl_clr) | fl_set;
  end

  // Flags and enables kept in separate flops, read as one control word
  assign icm = {ena, flg};

  assign src_fl = {icm[`PIC_B_T0F], icm[`PIC_B_X0F], icm[`PIC_B_PCF]};
  assign src_en = {icm[`PIC_B_T0E], icm[`PIC_B_X0E], icm[`PIC_B_PCE]};

  // Request gating per priority mode
  always_comb
  begin
    logic [2:0] act;
    logic       ph;
    logic       pl;
    act = src_fl & src_en;
    ph  = ((|(act & prio)) || (|(periph_req_i & peri_en & peri_prio)));
    pl  = ((|(act & ~prio)) || (|(periph_req_i & peri_en & ~peri_prio)));
    if (priority_scheme_enable)
    begin
      req_hi = ph && icm[`PIC_B_GHI];
      req_lo = pl && icm[`PIC_B_GLO] && icm[`PIC_B_GHI] && !in_high_o;
    end
    else
    begin
      req_hi = icm[`PIC_B_GHI] && ((|act) ||
               (icm[`PIC_B_GLO] && (|(periph_req_i & peri_en))));
      req_lo = 1'b0;
    end
  end

  // Latency counter from request to vectoring
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= pic_pkg::PIC_IDLE;
    else
      state <= next_state;
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      pic_pkg::PIC_IDLE: if (req_hi || req_lo) next_state = pic_pkg::PIC_WAIT;
      pic_pkg::PIC_WAIT:
        if (!(req_hi || req_lo))
          next_state = pic_pkg::PIC_IDLE;
        else if (lat_cnt == `PIC_LAT_CYC - 2'h1 && instr_end_i)
          next_state = pic_pkg::PIC_TAKE;
      pic_pkg::PIC_TAKE: next_state = pic_pkg::PIC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      lat_cnt <= 2'h0;
    else if (state != pic_pkg::PIC_WAIT)
      lat_cnt <= 2'h0;
    else if (lat_cnt != `PIC_LAT_CYC - 2'h1)
      lat_cnt <= lat_cnt + 2'h1;
  end

  // Priority chosen at acceptance, high first
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pend_hi <= 1'b0;
    else if (state == pic_pkg::PIC_WAIT)
      pend_hi <= req_hi;
  end
  assign take_hi = pend_hi;

  // Vector and stack outputs
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vector_req_o  <= 1'b0;
      stack_push_o  <= 1'b0;
      vector_addr_o <= `PIC_VEC_HIGH;
      stack_data_o  <= 21'h000000;
    end
    else
    begin
      vector_req_o <= (next_state == pic_pkg::PIC_TAKE);
      stack_push_o <= (next_state == pic_pkg::PIC_TAKE);
      if (next_state == pic_pkg::PIC_TAKE)
      begin
        vector_addr_o <= (req_hi || !priority_scheme_enable) ? `PIC_VEC_HIGH : `PIC_VEC_LOW;
        stack_data_o  <= return_addr_i;
      end
    end
  end

  // Service levels in progress
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_high_o <= 1'b0;
      in_low_o  <= 1'b0;
    end
    else if (state == pic_pkg::PIC_TAKE)
    begin
      if (take_hi || !priority_scheme_enable)
        in_high_o <= 1'b1;
      else
        in_low_o <= 1'b1;
    end
    else if (return_from_service_instr_i)
    begin
      if (in_high_o)
        in_high_o <= 1'b0;
      else
        in_low_o <= 1'b0;
    end
  end

  // Global enables and source enables
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ena <= 5'h00;
    else
    begin
      if (wr && wb_adr_i == `PIC_OFS_ICM)
        ena <= wb_dat_i[7:3];
      if (state == pic_pkg::PIC_TAKE)
      begin
        if (take_hi || !priority_scheme_enable)
          ena[`PIC_B_GHI] <= 1'b0;
        else
          ena[`PIC_B_GLO] <= 1'b0;
      end
      else if (return_from_service_instr_i)
      begin
        if (in_high_o)
          ena[`PIC_B_GHI] <= 1'b1;
        else if (in_low_o)
          ena[`PIC_B_GLO] <= 1'b1;
      end
    end
  end

  // Mode and priority registers
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      priority_scheme_enable <= 1'b0;
      prio                   <= 3'h7;
      peri_en                <= 8'h00;
      peri_prio              <= 8'hFF;
    end
    else if (wr)
    begin
      if (wb_adr_i == `PIC_OFS_RCR)
        priority_scheme_enable <= wb_dat_i[`PIC_B_PSE];
      if (wb_adr_i == `PIC_OFS_PRIO)
        prio <= wb_dat_i[2:0];
      if (wb_adr_i == `PIC_OFS_PERI)
      begin
        peri_en   <= wb_dat_i[7:0];
        peri_prio <= wb_dat_i[15:8];
      end
    end
  end

  // Read data, registered
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else if (acc)
    begin
      unique case (wb_adr_i)
        `PIC_OFS_ICM:  wb_dat_o <= {24'h000000, icm};
        `PIC_OFS_RCR:  wb_dat_o <= {24'h000000, priority_scheme_enable, 7'h00};
        `PIC_OFS_PRIO: wb_dat_o <= {29'h00000000, prio};
        `PIC_OFS_PERI: wb_dat_o <= {16'h0000, peri_prio, peri_en};
        `PIC_OFS_STAT: wb_dat_o <= {27'h0000000, state, in_low_o, in_high_o};
        default:       wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  AST_VEC_ADDR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    vector_req_o |-> (vector_addr_o == `PIC_VEC_HIGH || vector_addr_o == `PIC_VEC_LOW))
    else $error("vector address not a valid vector");
  AST_COMPAT_VEC: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (vector_req_o && !priority_scheme_enable) |-> vector_addr_o == `PIC_VEC_HIGH)
    else $error("compatibility vector not high");
  AST_GIE_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state == pic_pkg::PIC_TAKE && !priority_scheme_enable) |=> !icm[`PIC_B_GHI] || $past(wr))
    else $error("global enable not cleared");
  AST_PUSH: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    vector_req_o == stack_push_o)
    else $error("push and vector disagree");
  AST_NO_LOW_IN_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    in_high_o |-> !(vector_req_o && vector_addr_o == `PIC_VEC_LOW))
    else $error("low request during high service");
  AST_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    fl_set[2] |=> icm[`PIC_B_T0F])
    else $error("timer flag not set");
  sequence s_wait3;
    (state == pic_pkg::PIC_WAIT) [*3];
  endsequence
  AST_LAT: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (state == pic_pkg::PIC_IDLE ##1 state == pic_pkg::PIC_WAIT) |-> !vector_req_o [*2])
    else $error("vectored too early");
  AST_LAT_BOUND: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (s_wait3 ##0 instr_end_i && (req_hi || req_lo)) |=> state == pic_pkg::PIC_TAKE)
    else $error("vectoring late");
  AST_RET: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (return_from_service_instr_i && in_high_o && state != pic_pkg::PIC_TAKE && !wr) |=> icm[`PIC_B_GHI])
    else $error("enable not restored on return");
endmodule : pic_ctrl

//--- tb/pric_core_model.sv
// Purpose: core-side model that takes vectors and returns from service
// Assumes: shares the controller clock
// Notes: slow_i spaces instruction ends three cycles apart
`timescale 1ns/10ps
module pric_core_model (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               rstn_i,
  // Pace
  input  wire logic               slow_i,
  // Controller side
  input  wire logic               vector_req_i,
  input  wire logic               stack_push_i,
  input  wire pic_pkg::pic_addr_t stack_data_i,
  output logic                    instr_end_o,
  output logic                    ret_o,
  output pic_pkg::pic_addr_t      return_addr_o
);
  logic [1:0]         phase;
  pic_pkg::pic_addr_t stack_q[$];

  initial ret_o = 1'b0;

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      phase         <= 2'h0;
      instr_end_o   <= 1'b0;
      return_addr_o <= 21'h000100;
    end
    else
    begin
      phase       <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      instr_end_o <= !slow_i || (phase == 2'h2);
      if (vector_req_i && stack_push_i)
      begin
        stack_q.push_back(stack_data_i);
        return_addr_o <= pic_pkg::pic_addr_t'($urandom);
      end
    end
  end

  // One-cycle return pulse, then the pushed address comes back
  task automatic do_return();
    @(posedge sys_clk_i);
    ret_o <= 1'b1;
    @(posedge sys_clk_i);
    ret_o <= 1'b0;
    if (stack_q.size() > 0)
      return_addr_o <= stack_q.pop_back();
  endtask : do_return
endmodule : pric_core_model

//--- tb/test_prioritized_interrupt_controller.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model answers every vector request
// Notes: expected vectors queue up and a monitor pops them
`timescale 1ns/10ps
`include "pic_defs.svh"
module test_prioritized_interrupt_controller;
  logic               sys_clk_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [5:0]         wb_adr_i = 6'h00;
  logic [31:0]        wb_dat_i = 32'h0;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic               tmr = 1'b0;
  logic               pin = 1'b0;
  logic [3:0]         port = 4'h0;
  logic               prd = 1'b0;
  logic [7:0]         periph = 8'h00;
  logic               slow = 1'b0;
  logic               iend, ret, vreq, push, in_high_o, in_low_o;
  pic_pkg::pic_addr_t raddr, vaddr, sdata;
  pic_pkg::pic_addr_t exp_q[$];
  logic [31:0]        d;
  int                 n_mismatch = 0;
  int                 compares = 0;

  pic_ctrl pic_ctrl_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_zero_ovf_i(tmr), .ext_pin_zero_i(pin),
    .port_b_input_i(port), .port_b_read_i(prd), .periph_req_i(periph), .instr_end_i(iend),
    .return_from_service_instr_i(ret), .return_addr_i(raddr), .vector_req_o(vreq),
    .vector_addr_o(vaddr), .stack_push_o(push), .stack_data_o(sdata),
    .in_high_o(in_high_o), .in_low_o(in_low_o));

  pric_core_model pric_core_model_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .slow_i(slow), .vector_req_i(vreq),
    .stack_push_i(push), .stack_data_i(sdata), .instr_end_o(iend), .ret_o(ret),
    .return_addr_o(raddr));

  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic conclude();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Whole-word single accesses only, never a block move
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1);
  endtask : wb

  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    chk(d & m, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick

  task automatic tpulse();
    @(posedge sys_clk_i);
    tmr <= 1'b1;
    @(posedge sys_clk_i);
    tmr <= 1'b0;
  endtask : tpulse

  task automatic expv(input pic_pkg::pic_addr_t a);
    int n;
    exp_q.push_back(a);
    n = 0;
    while (exp_q.size() > 0 && n < 60)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(32'(n >= 3 && n < 60), 32'h1);
  endtask : expv

  always @(posedge sys_clk_i)
    if (vreq === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'(vaddr), 32'hFFFFFFFF);
      else
        chk(32'(vaddr), 32'(exp_q.pop_front()));
      chk(32'({push, sdata}), 32'({1'b1, raddr}));
    end

  initial
  begin
    #(20000 * 5);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    void'($urandom(68));
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    tick(4);
    rd(`PIC_OFS_ICM, 32'h0, 32'hFE);
    rd(`PIC_OFS_RCR, 32'h0, 32'hFF);
    rd(`PIC_OFS_PRIO, 32'h7, 32'hFF);
    rd(`PIC_OFS_PERI, 32'hFF00, 32'hFFFF);
    wr(6'h14, 32'hFFFFFFFF);
    rd(6'h14, 32'h0, 32'hFFFFFFFF);
    // Flags with every enable off
    tpulse();
    pin <= 1'b1;
    tick(6);
    rd(`PIC_OFS_ICM, 32'h6, 32'h6);
    pin <= 1'b0;
    port <= 4'($urandom_range(15, 1));
    tick(4);
    wr(`PIC_OFS_ICM, 32'h0);
    rd(`PIC_OFS_ICM, 32'h1, 32'h1);
    prd <= 1'b1;
    tick(1);
    prd <= 1'b0;
    tick(3);
    wr(`PIC_OFS_ICM, 32'h0);
    rd(`PIC_OFS_ICM, 32'h0, 32'h7);
    // Compatibility mode
    wr(`PIC_OFS_PRIO, 32'h0);
    wr(`PIC_OFS_PERI, 32'hFF);
    wr(`PIC_OFS_ICM, 32'h20);
    tpulse();
    tick(20);
    wr(`PIC_OFS_ICM, 32'hA4);
    expv(`PIC_VEC_HIGH);
    rd(`PIC_OFS_ICM, 32'h24, 32'hFF);
    chk(32'(in_high_o), 32'h1);
    wr(`PIC_OFS_ICM, 32'h20);
    pric_core_model_inst.do_return();
    tick(2);
    rd(`PIC_OFS_ICM, 32'hA0, 32'hFF);
    periph <= 8'h01 << $urandom_range(7, 0);
    tick(20);
    wr(`PIC_OFS_ICM, 32'hE0);
    expv(`PIC_VEC_HIGH);
    periph <= 8'h00;
    pric_core_model_inst.do_return();
    // Two-level mode with a slow core
    slow <= 1'b1;
    wr(`PIC_OFS_RCR, 32'h80);
    wr(`PIC_OFS_PRIO, 32'h2);
    wr(`PIC_OFS_ICM, 32'hB0);
    tpulse();
    tick(20);
    wr(`PIC_OFS_ICM, 32'hF4);
    expv(`PIC_VEC_LOW);
    rd(`PIC_OFS_ICM, 32'hB4, 32'hFF);
    pin <= 1'b1;
    expv(`PIC_VEC_HIGH);
    chk(32'({in_high_o, in_low_o}), 32'h3);
    rd(`PIC_OFS_ICM, 32'h36, 32'hFF);
    pin <= 1'b0;
    wr(`PIC_OFS_ICM, 32'h34);
    pric_core_model_inst.do_return();
    tick(20);
    rd(`PIC_OFS_ICM, 32'hB4, 32'hFF);
    wr(`PIC_OFS_ICM, 32'hB0);
    pric_core_model_inst.do_return();
    tick(2);
    rd(`PIC_OFS_ICM, 32'hF0, 32'hFF);
    // Both levels pending at once
    wr(`PIC_OFS_ICM, 32'h30);
    tpulse();
    pin <= 1'b1;
    tick(6);
    pin <= 1'b0;
    wr(`PIC_OFS_ICM, 32'hF6);
    expv(`PIC_VEC_HIGH);
    tick(20);
    chk(32'(in_low_o), 32'h0);
    wr(`PIC_OFS_ICM, 32'h74);
    pric_core_model_inst.do_return();
    expv(`PIC_VEC_LOW);
    wr(`PIC_OFS_ICM, 32'hB0);
    pric_core_model_inst.do_return();
    tick(4);
    chk(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule : test_prioritized_interrupt_controller
